// ---- common/mscc_pkg.sv ----
// package of the motor starter command channel: addresses, codes, field layouts and carriers
// Functional notes
// - channel selection parameter: 0 local terminals, 1 remote bus; resets to 0.
// - channel selection changes only while the motor is stopped.
// - forced local function may be assigned to terminal input two or three.
// - the assigned forced local input is active at level 1.
// - active forced local input makes terminals the command channel regardless of selection.
// - forced local input active: bus writes 6 or 16 answer exception 1.
// - in forced local, bus reads are still served; motor control from terminals.
// - plain local: terminal motor control, bus may read and write parameters.
// - forced local input wins over control bit 15.
// - remote command only allowed while terminal run input is 1.
// - bus active: all terminal commands ignored except stop from run input.
// - stop by dropping terminal run input is a freewheel stop.
// - control register at address 752, page 2 low 240, written by 6 or 16.
// - control bit 0: 1 runs, 0 stops with configured deceleration.
// - control bit 10 selects freewheel stop, acting with the bit 0 stop.
// - bit 11 second parameter set, bit 3 trip reset, others reserved.
// - control bit 15 set forces the local command channel.
// - status register at address 256, page 1 low 0, read by function 3.
// - status bits 0 ready, 1 on, 2 trip, 3 warning; bit 4 reserved.
// - status bit 14 shows forced local is in effect.
// - status bit 15 set while the motor ramps.
package mscc_pkg;

    // ************************************************************
    // bus addresses and function codes
    // ************************************************************
    localparam logic [15:0] STATUS_ADDR     = 16'h0100;
    localparam logic [15:0] CONTROL_ADDR    = 16'h02F0;
    localparam logic [15:0] CHAN_SEL_ADDR   = 16'h0E00;
    localparam logic [15:0] LIL_ASSIGN_ADDR = 16'h0E01;
    localparam logic [7:0]  FN_READ         = 8'h03;
    localparam logic [7:0]  FN_WRITE_ONE    = 8'h06;
    localparam logic [7:0]  FN_WRITE_MULTI  = 8'h10;
    localparam logic [7:0]  EXC_ILL_FUNC    = 8'h01;
    localparam logic [7:0]  EXC_ILL_ADDR    = 8'h02;
    localparam logic [7:0]  EXC_ILL_VALUE   = 8'h03;

    // ************************************************************
    // field layouts and reset values
    // ************************************************************
    localparam int CW_RUN        = 0;
    localparam int CW_TRIP_RESET = 3;
    localparam int CW_FREEWHEEL  = 10;
    localparam int CW_SECOND_SET = 11;
    localparam int CW_FORCE_LOC  = 15;
    localparam int SW_READY      = 0;
    localparam int SW_ON         = 1;
    localparam int SW_TRIP       = 2;
    localparam int SW_WARNING    = 3;
    localparam int SW_IN_THREE   = 5;
    localparam int SW_IN_TWO     = 6;
    localparam int SW_RUN_IN     = 7;
    localparam int SW_FORCED     = 14;
    localparam int SW_RAMPING    = 15;
    localparam logic        CHAN_LOCAL    = 1'b0;
    localparam logic        CHAN_REMOTE   = 1'b1;
    localparam logic        CHAN_RESET    = 1'b0;
    localparam logic [1:0]  LIL_NONE      = 2'h0;
    localparam logic [1:0]  LIL_ON_TWO    = 2'h1;
    localparam logic [1:0]  LIL_ON_THREE  = 2'h2;
    localparam logic [1:0]  LIL_RESET     = 2'h0;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;

    // ************************************************************
    // modes and carriers
    // ************************************************************
    typedef enum logic [2:0] {
        MODE_LOCAL  = 3'b001,
        MODE_REMOTE = 3'b010,
        MODE_FORCED = 3'b100
    } mscc_mode_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] data;
    } mscc_req_t;

    typedef struct packed {
        logic        valid;
        logic        exc;
        logic [7:0]  code;
        logic [15:0] data;
    } mscc_rsp_t;

    typedef struct packed {
        logic on;
        logic ramping;
        logic trip;
        logic warning;
    } mscc_motor_t;

    typedef struct packed {
        logic run;
        logic freewheel;
        logic trip_reset;
        logic second_set;
        logic remote;
        logic forced;
    } mscc_cmd_t;

endpackage : mscc_pkg

// ---- hw/mscc_in_sync.sv ----
// three-stage input synchroniser that passes a change once the last two stages agree
module mscc_in_sync (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic pin,
    output logic      level
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } mscc_sync_t;

    mscc_sync_t s;
    mscc_sync_t next_s;

    // s1 feeds only s2 so a metastable sample never reaches a decision
    always_comb begin
        next_s    = s;
        next_s.s1 = pin;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        if (s.s2 == s.s3) begin
            next_s.level = s.s3;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign level = s.level;

endmodule : mscc_in_sync

// ---- hw/mscc_top.sv ----
// motor starter command channel: bus register access, channel arbitration, command decode
module mscc_top (
    input  wire logic               core_clk,
    input  wire logic               nrst,
    input  wire logic               terminal_run_input,
    input  wire logic               terminal_input_two,
    input  wire logic               terminal_input_three,
    input  wire mscc_pkg::mscc_req_t   req,
    input  wire mscc_pkg::mscc_motor_t motor,
    output mscc_pkg::mscc_rsp_t     rsp,
    output mscc_pkg::mscc_cmd_t     cmd,
    output mscc_pkg::mscc_mode_t    mode
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic                 chan_sel;
        logic [1:0]           lil_assign;
        logic [15:0]          control;
        mscc_pkg::mscc_mode_t mode;
        mscc_pkg::mscc_cmd_t  cmd;
        mscc_pkg::mscc_rsp_t  rsp;
    } mscc_state_t;

    mscc_state_t s;
    mscc_state_t next_s;

    logic        run_in;
    logic        in_two;
    logic        in_three;
    logic        forced_in;
    logic        forced_any;
    logic        remote_ok;
    logic        is_read;
    logic        is_write;
    logic [15:0] status_word;

    // ************************************************************
    // terminal input synchronisers
    // ************************************************************
    mscc_in_sync u_sync_run (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pin      (terminal_run_input),
        .level    (run_in)
    );

    mscc_in_sync u_sync_two (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pin      (terminal_input_two),
        .level    (in_two)
    );

    mscc_in_sync u_sync_three (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pin      (terminal_input_three),
        .level    (in_three)
    );

    // ************************************************************
    // channel arbitration
    // ************************************************************
    // the assigned input is active high and needs no bus help
    assign forced_in = ((s.lil_assign == mscc_pkg::LIL_ON_TWO) && in_two) ||
                       ((s.lil_assign == mscc_pkg::LIL_ON_THREE) && in_three);
    // the input stands on its own, so control bit 15 cannot cancel it
    assign forced_any = forced_in || s.control[mscc_pkg::CW_FORCE_LOC];
    // remote commands also need the terminal run input held high
    assign remote_ok = (s.chan_sel == mscc_pkg::CHAN_REMOTE) && !forced_any && run_in;

    assign is_read  = (req.func == mscc_pkg::FN_READ);
    assign is_write = (req.func == mscc_pkg::FN_WRITE_ONE) ||
                      (req.func == mscc_pkg::FN_WRITE_MULTI);

    // ************************************************************
    // status word
    // ************************************************************
    always_comb begin
        status_word                          = 16'h0000;
        status_word[mscc_pkg::SW_READY]      = remote_ok && !motor.trip;
        status_word[mscc_pkg::SW_ON]         = motor.on;
        status_word[mscc_pkg::SW_TRIP]       = motor.trip;
        status_word[mscc_pkg::SW_WARNING]    = motor.warning;
        status_word[mscc_pkg::SW_IN_THREE]   = in_three;
        status_word[mscc_pkg::SW_IN_TWO]     = in_two;
        status_word[mscc_pkg::SW_RUN_IN]     = run_in;
        status_word[mscc_pkg::SW_FORCED]     = forced_any;
        status_word[mscc_pkg::SW_RAMPING]    = motor.ramping;
    end

    // ************************************************************
    // request handling and command decode
    // ************************************************************
    always_comb begin
        next_s                = s;
        next_s.rsp            = '0;
        next_s.cmd.trip_reset = 1'b0;

        if (req.valid) begin
            next_s.rsp.valid = 1'b1;
            if (!(is_read || is_write)) begin
                next_s.rsp.exc  = 1'b1;
                next_s.rsp.code = mscc_pkg::EXC_ILL_FUNC;
            end else if (is_write && forced_in) begin
                // only the keypads may change parameters now
                next_s.rsp.exc  = 1'b1;
                next_s.rsp.code = mscc_pkg::EXC_ILL_FUNC;
            end else if (is_read) begin
                // reads stay open in every mode
                case (req.addr)
                    mscc_pkg::STATUS_ADDR: begin
                        next_s.rsp.data = status_word;
                    end
                    mscc_pkg::CHAN_SEL_ADDR: begin
                        next_s.rsp.data = {15'h0000, s.chan_sel};
                    end
                    mscc_pkg::LIL_ASSIGN_ADDR: begin
                        next_s.rsp.data = {14'h0000, s.lil_assign};
                    end
                    default: begin
                        next_s.rsp.exc  = 1'b1;
                        next_s.rsp.code = mscc_pkg::EXC_ILL_ADDR;
                    end
                endcase
            end else begin
                case (req.addr)
                    mscc_pkg::CONTROL_ADDR: begin
                        next_s.control = req.data;
                        if (req.data[mscc_pkg::CW_TRIP_RESET] && remote_ok) begin
                            next_s.cmd.trip_reset = 1'b1;
                        end
                    end
                    mscc_pkg::CHAN_SEL_ADDR: begin
                        if (req.data > 16'h0001) begin
                            next_s.rsp.exc  = 1'b1;
                            next_s.rsp.code = mscc_pkg::EXC_ILL_VALUE;
                        end else if (!motor.on) begin
                            // a running motor keeps its channel; the write is still acknowledged
                            next_s.chan_sel = req.data[0];
                        end
                    end
                    mscc_pkg::LIL_ASSIGN_ADDR: begin
                        if (req.data > 16'h0002) begin
                            next_s.rsp.exc  = 1'b1;
                            next_s.rsp.code = mscc_pkg::EXC_ILL_VALUE;
                        end else begin
                            next_s.lil_assign = req.data[1:0];
                        end
                    end
                    default: begin
                        next_s.rsp.exc  = 1'b1;
                        next_s.rsp.code = mscc_pkg::EXC_ILL_ADDR;
                    end
                endcase
            end
        end

        // mode follows selection unless forcing takes the channel
        if (forced_any) begin
            next_s.mode = mscc_pkg::MODE_FORCED;
        end else if (s.chan_sel == mscc_pkg::CHAN_REMOTE) begin
            next_s.mode = mscc_pkg::MODE_REMOTE;
        end else begin
            next_s.mode = mscc_pkg::MODE_LOCAL;
        end

        next_s.cmd.forced = forced_any;
        next_s.cmd.remote = remote_ok;
        case (next_s.mode)
            mscc_pkg::MODE_REMOTE: begin
                // terminals only contribute the run input stop
                next_s.cmd.run        = s.control[mscc_pkg::CW_RUN] && run_in;
                next_s.cmd.freewheel  = !run_in ||
                                        (!s.control[mscc_pkg::CW_RUN] &&
                                         s.control[mscc_pkg::CW_FREEWHEEL]);
                next_s.cmd.second_set = s.control[mscc_pkg::CW_SECOND_SET] && run_in;
            end
            mscc_pkg::MODE_LOCAL, mscc_pkg::MODE_FORCED: begin
                next_s.cmd.run        = run_in;
                next_s.cmd.freewheel  = !run_in;
                next_s.cmd.second_set = 1'b0;
            end
            default: begin
                next_s.cmd.run        = 1'b0;
                next_s.cmd.freewheel  = 1'b1;
                next_s.cmd.second_set = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            s            <= '0;
            s.chan_sel   <= mscc_pkg::CHAN_RESET;
            s.lil_assign <= mscc_pkg::LIL_RESET;
            s.control    <= mscc_pkg::CONTROL_RESET;
            s.mode       <= mscc_pkg::MODE_LOCAL;
            s.cmd.freewheel <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign rsp  = s.rsp;
    assign cmd  = s.cmd;
    assign mode = s.mode;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence seq_write_req;
        req.valid && is_write;
    endsequence

    sequence seq_exc_func;
        s.rsp.valid && s.rsp.exc && (s.rsp.code == mscc_pkg::EXC_ILL_FUNC);
    endsequence

    chk_chan_hold: assert property (motor.on |=> $stable(s.chan_sel))
        else $error("channel selection changed while motor ran");
    chk_forced_mode: assert property (forced_in |=> s.mode == mscc_pkg::MODE_FORCED)
        else $error("forced input did not force local mode");
    chk_write_reject: assert property ((seq_write_req and forced_in) |=> seq_exc_func)
        else $error("write under forced local not rejected");
    chk_status_read: assert property (req.valid && is_read &&
                                      req.addr == mscc_pkg::STATUS_ADDR
                                      |=> s.rsp.valid && !s.rsp.exc)
        else $error("status read not served");
    chk_control_store: assert property ((seq_write_req and !forced_in and
                                         req.addr == mscc_pkg::CONTROL_ADDR)
                                        |=> s.control == $past(req.data))
        else $error("control write not stored");
    chk_bit15_priority: assert property (forced_in && s.control[mscc_pkg::CW_FORCE_LOC]
                                         |=> s.cmd.forced && s.mode == mscc_pkg::MODE_FORCED)
        else $error("forced input lost with bit 15 set");
    chk_run_gate: assert property (!run_in |=> !s.cmd.run && !s.cmd.remote)
        else $error("run commanded without run input");
    chk_stop_freewheel: assert property (!run_in ##1 !run_in |-> s.cmd.freewheel)
        else $error("terminal stop not freewheel");
    chk_remote_run: assert property (s.mode == mscc_pkg::MODE_REMOTE && run_in &&
                                     $stable(run_in) && s.control[mscc_pkg::CW_RUN] &&
                                     $stable(s.control) && $stable(s.mode)
                                     |=> s.cmd.run)
        else $error("remote run bit not obeyed");
    chk_forced_flag: assert property (req.valid && is_read && !forced_any &&
                                      req.addr == mscc_pkg::STATUS_ADDR
                                      |=> !s.rsp.data[mscc_pkg::SW_FORCED])
        else $error("status shows forced local wrongly");

endmodule : mscc_top

// ---- test/mscc_host_model.sv ----
// bus master model that issues single register requests on the command channel
module mscc_host_model (
    input  wire logic                core_clk,
    output mscc_pkg::mscc_req_t      req,
    input  wire mscc_pkg::mscc_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ns;

    initial req = '0;

    // ************************************************************
    // request task
    // ************************************************************
    // a random idle gap mixes prompt and slow masters; released fields are inverted
    task automatic bus_xfer(input  logic [7:0]          f,
                            input  logic [15:0]         a,
                            input  logic [15:0]         d,
                            output mscc_pkg::mscc_rsp_t r);
        repeat ($urandom_range(0, 2)) @(posedge core_clk);
        @(posedge core_clk);
        req <= '{valid: 1'b1, func: f, addr: a, data: d};
        @(posedge core_clk);
        req <= '{valid: 1'b0, func: ~f, addr: ~a, data: ~d};
        #1;
        r = rsp;
    endtask : bus_xfer

endmodule : mscc_host_model

// ---- test/testbench.sv ----
// self-checking bench of the command channel against a behavioural model
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  core_clk;
    logic                  nrst;
    logic                  terminal_run_input;
    logic                  terminal_input_two;
    logic                  terminal_input_three;
    mscc_pkg::mscc_req_t   req;
    mscc_pkg::mscc_motor_t motor;
    mscc_pkg::mscc_rsp_t   rsp;
    mscc_pkg::mscc_cmd_t   cmd;
    mscc_pkg::mscc_mode_t  mode;
    int                    miscompares;
    int                    n_tests;
    int                    m_chan;
    int                    m_lil;
    logic [15:0]           m_ctrl;

    mscc_top dut_u (.core_clk(core_clk), .nrst(nrst), .terminal_run_input(terminal_run_input),
        .terminal_input_two(terminal_input_two), .terminal_input_three(terminal_input_three),
        .req(req), .motor(motor), .rsp(rsp), .cmd(cmd), .mode(mode));
    mscc_host_model host_u (.core_clk(core_clk), .req(req), .rsp(rsp));

    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;

    // ************************************************************
    // model and checks
    // ************************************************************
    function automatic logic forced_in();
        return (m_lil == 1 && terminal_input_two) || (m_lil == 2 && terminal_input_three);
    endfunction : forced_in

    function automatic logic forced_any();
        return forced_in() || m_ctrl[15];
    endfunction : forced_any

    function automatic logic remote_ok();
        return m_chan == 1 && !forced_any() && terminal_run_input;
    endfunction : remote_ok

    function automatic logic [15:0] exp_status();
        logic [15:0] s;
        s = 16'h0000;
        s[0] = remote_ok() && !motor.trip;
        s[1] = motor.on;
        s[2] = motor.trip;
        s[3] = motor.warning;
        s[5] = terminal_input_three;
        s[6] = terminal_input_two;
        s[7] = terminal_run_input;
        s[14] = forced_any();
        s[15] = motor.ramping;
        return s;
    endfunction : exp_status

    task automatic chk(input logic ok, input string what);
        n_tests++;
        if (!ok) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : chk

    task automatic stop_test();
        $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk_levels();
        mscc_pkg::mscc_mode_t em;
        logic                 rn;
        rn = terminal_run_input;
        em = forced_any() ? mscc_pkg::MODE_FORCED :
             (m_chan == 1 ? mscc_pkg::MODE_REMOTE : mscc_pkg::MODE_LOCAL);
        chk(mode === em, "active channel");
        if (em == mscc_pkg::MODE_REMOTE) begin
            chk(cmd.run === (m_ctrl[0] && rn), "remote run");
            chk(cmd.freewheel === (!rn || (!m_ctrl[0] && m_ctrl[10])), "stop kind");
            chk(cmd.second_set === (m_ctrl[11] && rn), "second set");
        end else begin
            chk(cmd.run === rn && cmd.freewheel === !rn && cmd.second_set === 1'b0, "local");
        end
        chk(cmd.remote === (em == mscc_pkg::MODE_REMOTE && rn), "remote flag");
        chk(cmd.forced === forced_any(), "forced flag");
    endtask : chk_levels

    task automatic do_req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
        mscc_pkg::mscc_rsp_t r;
        logic [7:0]          ec;
        logic [15:0]         ed;
        logic                tr;
        ec = 8'h00;
        ed = 16'h0000;
        tr = 1'b0;
        if (f != mscc_pkg::FN_READ && f != mscc_pkg::FN_WRITE_ONE && f != mscc_pkg::FN_WRITE_MULTI)
            ec = mscc_pkg::EXC_ILL_FUNC;
        else if (f != mscc_pkg::FN_READ && forced_in()) ec = mscc_pkg::EXC_ILL_FUNC;
        else if (f == mscc_pkg::FN_READ) begin
            if (a == mscc_pkg::STATUS_ADDR) ed = exp_status();
            else if (a == mscc_pkg::CHAN_SEL_ADDR) ed = 16'(m_chan);
            else if (a == mscc_pkg::LIL_ASSIGN_ADDR) ed = 16'(m_lil);
            else ec = mscc_pkg::EXC_ILL_ADDR;
        end else if (a == mscc_pkg::CONTROL_ADDR) begin
            tr = d[3] && remote_ok();
            m_ctrl = d;
        end else if (a == mscc_pkg::CHAN_SEL_ADDR) begin
            if (d > 1) ec = mscc_pkg::EXC_ILL_VALUE;
            else if (!motor.on) m_chan = int'(d);
        end else if (a == mscc_pkg::LIL_ASSIGN_ADDR) begin
            if (d > 2) ec = mscc_pkg::EXC_ILL_VALUE;
            else m_lil = int'(d);
        end else ec = mscc_pkg::EXC_ILL_ADDR;
        host_u.bus_xfer(f, a, d, r);
        chk(r.valid === 1'b1 && r.exc === (ec != 8'h00) && r.data === ed, "answer");
        chk(r.code === ec, "exception code");
        chk(cmd.trip_reset === tr, "trip reset");
        repeat (2) @(posedge core_clk);
        #1;
        chk_levels();
    endtask : do_req

    task automatic set_pins(input logic r, input logic t2, input logic t3, input logic [3:0] m);
        @(posedge core_clk);
        terminal_run_input <= r;
        terminal_input_two <= t2;
        terminal_input_three <= t3;
        motor <= mscc_pkg::mscc_motor_t'(m);
        repeat (6) @(posedge core_clk);
        #1;
        chk_levels();
    endtask : set_pins

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        logic [15:0] ctl [6];
        logic [15:0] adr [5];
        logic [7:0]  fn  [4];
        logic [15:0] a;
        ctl = '{16'h0001, 16'h0400, 16'h0809, 16'h0008, 16'h8001, 16'h0000};
        adr = '{16'h0100, 16'h02F0, 16'h0E00, 16'h0E01, 16'h0123};
        fn = '{8'h03, 8'h06, 8'h10, 8'h07};
        miscompares = 0;
        n_tests = 0;
        m_chan = 0;
        m_lil = 0;
        m_ctrl = 16'h0000;
        nrst = 1'b0;
        terminal_run_input = 1'b0;
        terminal_input_two = 1'b0;
        terminal_input_three = 1'b0;
        motor = '0;
        void'($urandom(32'hD562D1DC));
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        #1;
        chk_levels();
        do_req(8'h03, 16'h0E00, 16'h0000);
        do_req(8'h03, 16'h0E01, 16'h0000);
        set_pins(1'b1, 1'b0, 1'b0, 4'h0);
        do_req(8'h06, 16'h02F0, 16'h0001);
        do_req(8'h06, 16'h0E00, 16'h0001);
        foreach (ctl[i]) do_req(8'h10, 16'h02F0, ctl[i]);
        do_req(8'h06, 16'h02F0, 16'h0001);
        set_pins(1'b0, 1'b1, 1'b1, 4'h0);
        set_pins(1'b1, 1'b0, 1'b0, 4'h8);
        do_req(8'h06, 16'h0E00, 16'h0000);
        set_pins(1'b1, 1'b0, 1'b0, 4'h0);
        for (int p = 1; p <= 2; p++) begin
            do_req(8'h06, 16'h0E01, 16'(p));
            do_req(8'h06, 16'h02F0, 16'h8001);
            set_pins(1'b1, p == 1, p == 2, 4'h2);
            do_req(8'h06, 16'h02F0, 16'h0000);
            do_req(8'h10, 16'h02F0, 16'h8000);
            do_req(8'h03, 16'h0100, 16'h0000);
            set_pins(1'b1, 1'b0, 1'b0, 4'h0);
        end
        foreach (fn[i]) do_req(fn[i], 16'h0100, 16'h0000);
        do_req(8'h03, 16'h02F0, 16'h0000);
        do_req(8'h06, 16'h0E00, 16'h0002);
        do_req(8'h06, 16'h0E01, 16'h0003);
        for (int i = 0; i < 300; i++) begin
            if (i % 8 == 0) begin
                set_pins($urandom_range(0, 3) != 0, 1'($urandom), 1'($urandom), 4'($urandom));
            end
            a = adr[$urandom_range(0, 4)];
            do_req(fn[$urandom_range(0, 3)], a,
                   a[11] ? 16'($urandom_range(0, 3)) : 16'($urandom));
        end
        stop_test();
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        stop_test();
    end

endmodule : testbench
